/* dv/cidp_core_test.sv */
// Self-checking bench for the core decoder with a behavioural shared side.
// Assumes: programs are loaded and results read while the core is stopped.
`timescale 1ns/100ps

module cidp_core_test;
  import cidp_pkg::*;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [9:0]        addr = 10'h000;
  logic [31:0]       wr_data = 32'h0;
  logic              wr_stb = 1'b0;
  logic              rd_stb = 1'b0;
  logic [31:0]       rd_data;
  logic [2:0]        core_index = 3'h5;
  logic              hub_req;
  cidp_hub_kind_type hub_kind;
  logic              hub_write;
  logic [2:0]        hub_sub;
  logic [15:0]       hub_addr;
  logic [31:0]       hub_wdata;
  logic              hub_ack;
  logic [31:0]       hub_rdata;
  logic              hub_carry;
  logic [3:0]        lat = 4'h0;
  logic [31:0]       got;
  logic [31:0]       st;
  logic              z = 1'b0;
  logic              c = 1'b0;
  int                miscompares = 0;
  int                n_compared = 0;

  always #5 clk = ~clk;

  cidp_core cidp_core_i (.clk, .reset_n, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .core_index,
    .hub_req, .hub_kind, .hub_write, .hub_sub, .hub_addr, .hub_wdata, .hub_ack, .hub_rdata, .hub_carry);
  cidp_hub_model cidp_hub_model_i (.clk, .hub_req, .hub_kind, .hub_write, .hub_sub, .hub_addr,
    .hub_wdata, .lat, .hub_ack, .hub_rdata, .hub_carry);

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic halt_core();
    wr(10'h200, 32'h0);
    st = 32'h0;
    for (int k = 0; k < 20 && st[14] !== 1'b1; k++) rd(10'h201, st);
    check(st & 32'h4000, 32'h4000);
  endtask

  // One instruction at 0, parking jumps at 1 and 2, operands at 0x10 and 0x11
  task automatic run(input logic [31:0] ins, input logic [31:0] dv, input logic [31:0] sv);
    wr(10'h000, ins);
    wr(10'h001, {6'h17, 4'b0001, 4'hf, 9'h0, 9'h1});
    wr(10'h002, {6'h17, 4'b0001, 4'hf, 9'h0, 9'h2});
    wr(10'h010, dv);
    wr(10'h011, sv);
    wr(10'h200, 32'h1);
    // Long enough for the slowest shared answer used here
    repeat (40) @(posedge clk);
    halt_core();
    rd(10'h010, got);
  endtask

  function automatic logic [33:0] calc(input logic [5:0] op, input logic [31:0] d, s, input logic ci);
    logic [4:0]  n;
    logic [31:0] r;
    logic [31:0] f;
    logic        cy;
    n  = s[4:0];
    f  = ci ? 32'hffffffff : 32'h0;
    cy = op[0] ? d[31] : d[0];
    case (op)
      6'h08: r = (d >> n) | (d << (6'd32 - n));
      6'h09: r = (d << n) | (d >> (6'd32 - n));
      6'h0a: r = d >> n;
      6'h0b: r = d << n;
      6'h0c: r = (d >> n) | (f & ~(32'hffffffff >> n));
      6'h0d: r = (d << n) | (f & ~(32'hffffffff << n));
      6'h0e: r = $signed(d) >>> n;
      6'h0f: for (int j = 0; j < 32; j++) r[j] = (j + n < 32) ? d[31-j-n] : 1'b0;
      6'h10: r = ($signed(d) < $signed(s)) ? s : d;
      6'h11: r = ($signed(d) >= $signed(s)) ? s : d;
      6'h12: r = (d < s) ? s : d;
      6'h13: r = (d >= s) ? s : d;
      6'h14: r = {d[31:9], s[8:0]};
      6'h15: r = {d[31:18], s[8:0], d[8:0]};
      6'h16: r = {s[8:0], d[22:0]};
      default: r = d;
    endcase
    if (op == 6'h0f) cy = d[0];
    if (op[5:1] == 5'h08) cy = $signed(d) < $signed(s);
    if (op[5:1] == 5'h09) cy = d < s;
    return {(op[5:2] == 4'h4) ? d == s : r == 32'h0, cy, r};
  endfunction

  task automatic alu(input logic [5:0] op, input logic [3:0] zcri, input logic [31:0] d, s);
    logic [33:0] e;
    e = calc(op, d, zcri[0] ? {23'h0, s[8:0]} : s, c);
    run({op, zcri, 4'hf, 9'h010, zcri[0] ? s[8:0] : 9'h011}, d, s);
    if (zcri[3]) z = e[33];
    if (zcri[2] && op < 6'h14) c = e[32];
    check(got, zcri[1] ? e[31:0] : d);
    check(st[13:12], {c, z});
  endtask

  task automatic hub(input logic [5:0] op, input logic [3:0] zcri, input logic [8:0] s,
                     input logic [31:0] dv, input logic [31:0] exp);
    run({op, zcri, 4'hf, 9'h010, s}, dv, 32'h0);
    check(got, exp);
  endtask

  ////////////////////////////////////////
  task automatic reset_test();
    rd(10'h201, st);
    check(st & 32'hffff, 32'h4000);
    wr(10'h2a0, 32'hffffffff);
    rd(10'h2a0, got);
    check(got, 32'h0);
    $display("done: reset");
  endtask

  task automatic alu_tests();
    alu(6'h08, 4'b1111, 32'h80000001, 32'h4);
    alu(6'h09, 4'b1111, 32'h80000001, 32'h1);
    alu(6'h0a, 4'b1111, 32'h80000003, 32'h1f);
    alu(6'h0b, 4'b1111, 32'h80000001, 32'h0);
    alu(6'h0c, 4'b1111, 32'h10, 32'h4);
    alu(6'h0d, 4'b1111, 32'h80000000, 32'h1);
    alu(6'h0d, 4'b1111, 32'h1, 32'h3);
    alu(6'h0e, 4'b1111, 32'h80000010, 32'h4);
    alu(6'h0f, 4'b1111, 32'h1, 32'h0);
    alu(6'h0f, 4'b1111, 32'hf1, 32'h1c);
    alu(6'h10, 4'b1111, 32'hfffffffb, 32'h3);
    alu(6'h11, 4'b1111, 32'h5, 32'h3);
    alu(6'h12, 4'b1111, 32'hfffffffb, 32'h3);
    alu(6'h13, 4'b1111, 32'h3, 32'h3);
    alu(6'h14, 4'b1111, 32'hffffffff, 32'h0);
    alu(6'h15, 4'b1111, 32'h0, 32'h1ff);
    alu(6'h16, 4'b1111, 32'h0, 32'h1ff);
    alu(6'h0b, 4'b1110, 32'h1, 32'h24);
    alu(6'h08, 4'b1101, 32'h3, 32'h1);
    alu(6'h0b, 4'b0011, 32'h0, 32'h1);
    for (int i = 4; i < 8; i++) alu(i[5:0], 4'b0011, 32'h7, 32'h2);
    run({6'h08, 4'b1111, 4'h0, 9'h010, 9'h4}, 32'h1, 32'h0);
    check(got, 32'h1);
    check(st[13:12], {c, z});
    $display("done: alu");
  endtask

  task automatic jump_tests();
    hub(6'h17, 4'b0011, 9'h2, 32'hffffffff, 32'hfffffe01);
    check(st[8:0], 9'h2);
    hub(6'h17, 4'b0001, 9'h2, 32'h5, 32'h5);
    check(st[8:0], 9'h2);
    $display("done: jump");
  endtask

  task automatic timing();
    logic [8:0] p;
    int         last;
    for (int i = 0; i < 6; i++) wr(i[9:0], {6'h0b, 4'b0001, 4'hf, 9'h10, 9'h1});
    wr(10'h006, {6'h17, 4'b0001, 4'hf, 9'h0, 9'h6});
    wr(10'h200, 32'h1);
    @(posedge clk);
    addr   <= 10'h201;
    rd_stb <= 1'b1;
    p    = 9'h0;
    last = -1;
    for (int t = 0; t < 30; t++) begin
      @(posedge clk);
      #1;
      if (rd_data[8:0] !== p) begin
        if (last >= 0) check(t - last, 4);
        last = t;
        p    = rd_data[8:0];
      end
    end
    @(posedge clk);
    rd_stb <= 1'b0;
    check(p, 9'h6);
    halt_core();
    $display("done: timing");
  endtask

  task automatic hub_tests();
    hub(6'h00, 4'b0001, 9'h021, 32'h123456a5, 32'h123456a5);
    lat = 4'hb;
    hub(6'h00, 4'b1011, 9'h021, 32'hffffffff, 32'ha5);
    hub(6'h01, 4'b0001, 9'h022, 32'h1234beef, 32'h1234beef);
    hub(6'h01, 4'b1011, 9'h022, 32'hffffffff, 32'hbeef);
    check(st[12], 1'b0);
    lat = 4'h0;
    hub(6'h02, 4'b0001, 9'h024, 32'h87654321, 32'h87654321);
    hub(6'h02, 4'b1011, 9'h024, 32'h0, 32'h87654321);
    hub(6'h02, 4'b1011, 9'h030, 32'hffffffff, 32'h0);
    check(st[12], 1'b1);
    hub(6'h03, 4'b0001, 9'h0, 32'h15a, 32'h15a);
    check(cidp_hub_model_i.clk_cfg, 8'h5a);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      core_index <= i ? 3'h5 : 3'h0;
      hub(6'h03, 4'b1011, 9'h1, 32'hffffffff, i ? 32'h5 : 32'h0);
      check(st[12], i == 0);
    end
    for (int i = 0; i < 4; i++) begin
      hub(6'h03, 4'b0101, i == 2 ? 9'h3 : 9'h2, 32'h0, 32'h0);
      if (i != 2) check(st[13], i == 1);
    end
    for (int i = 0; i < 9; i++) begin
      hub(6'h03, i < 8 ? 4'b1111 : 4'b0101, 9'h4, 32'hffffffff, i < 8 ? i : 32'hffffffff);
      check(st[13], i == 8);
    end
    hub(6'h03, 4'b0001, 9'h5, 32'h3, 32'h3);
    hub(6'h03, 4'b1111, 9'h4, 32'hffffffff, 32'h3);
    for (int i = 0; i < 4; i++) begin
      hub(6'h03, 4'b0101, i < 2 ? 9'h6 : 9'h7, 32'h3, 32'h3);
      check(st[13], i == 1 || i == 2);
    end
    $display("done: shared");
  endtask

  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Compared %0d values, %0d mismatches", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    reset_test();
    alu_tests();
    jump_tests();
    timing();
    hub_tests();
    tally_and_finish();
  end

  // About 57 programs of under 100 cycles each; far beyond that means a hang
  initial begin
    #300000;
    miscompares++;
    tally_and_finish();
  end
endmodule // cidp_core_test

/* dv/cidp_hub_model.sv */
// Behavioural shared memory and resource arbiter facing one core.
// Assumes: the core's clock; the bench sets the answer latency in cycles.
`timescale 1ns/100ps

module cidp_hub_model (
  input  wire logic                        clk,
  input  wire logic                        hub_req,
  input  wire cidp_pkg::cidp_hub_kind_type hub_kind,
  input  wire logic                        hub_write,
  input  wire logic [2:0]                  hub_sub,
  input  wire logic [15:0]                 hub_addr,
  input  wire logic [31:0]                 hub_wdata,
  input  wire logic [3:0]                  lat,
  output logic                             hub_ack,
  output logic      [31:0]                 hub_rdata,
  output logic                             hub_carry
);
  import cidp_pkg::*;
  logic [7:0] mem [0:4095];
  logic [7:0] clk_cfg;
  logic [7:0] lk_used;
  logic [7:0] lk_state;
  logic [3:0] cnt;
  logic       hold;
  int         free_cores;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {clk_cfg, lk_used, lk_state, cnt, hold} = '0;
    {hub_ack, hub_rdata, hub_carry} = '0;
    free_cores = 1;
  end

  ////////////////////////////////////////
  task automatic serve();
    logic [11:0] a;
    logic [2:0]  n;
    logic [2:0]  k;
    a = hub_addr[11:0];
    n = hub_wdata[2:0];
    k = 3'h0;
    hub_carry <= 1'b0;
    hub_rdata <= {24'h5a5a5a, mem[a]};
    case (hub_kind)
      HK_BYTE: if (hub_write) mem[a] = hub_wdata[7:0];
      HK_HALF: if (hub_write) {mem[a+1], mem[a]} = hub_wdata[15:0];
               else hub_rdata <= {16'ha5a5, mem[a+1], mem[a]};
      HK_LONG: if (hub_write) {mem[a+3], mem[a+2], mem[a+1], mem[a]} = hub_wdata;
               else hub_rdata <= {mem[a+3], mem[a+2], mem[a+1], mem[a]};
      default: case (hub_sub)
        3'h0: clk_cfg = hub_wdata[7:0];
        3'h2: begin
          hub_carry <= (free_cores == 0);
          if (free_cores > 0) free_cores--;
        end
        3'h3: free_cores++;
        3'h4: begin
          for (int i = 7; i >= 0; i--) if (!lk_used[i]) k = i[2:0];
          hub_carry <= &lk_used;
          hub_rdata <= {29'h0, k};
          if (!(&lk_used)) lk_used[k] = 1'b1;
        end
        3'h5: lk_used[n] = 1'b0;
        3'h6: begin
          hub_carry <= lk_state[n];
          lk_state[n] = 1'b1;
        end
        3'h7: begin
          hub_carry <= lk_state[n];
          lk_state[n] = 1'b0;
        end
        default: ;
      endcase
    endcase
  endtask

  always @(posedge clk) begin
    hub_ack   <= 1'b0;
    // Idle answer lines toggle so stale data never looks valid
    hub_rdata <= ~hub_rdata;
    hub_carry <= ~hub_carry;
    if (!hub_req) hold <= 1'b0;
    if (hub_req && !hold) begin
      cnt <= cnt + 4'h1;
      if (cnt == lat) begin
        cnt     <= 4'h0;
        hold    <= 1'b1;
        hub_ack <= 1'b1;
        serve();
      end
    end
  end
endmodule // cidp_hub_model

/* rtl/cidp_core.sv */
// Instruction decode and execute for the memory, shared-resource, shift,
// limit, field-insert and jump group of a small 32-bit core.
// Assumes: shared-memory arbiter on the same clock answers hub_req with one
// hub_ack pulse; software loads the register memory while the core is stopped.
`timescale 1ns/100ps
`include "cidp_defs.svh"

// How it works
// - Word splits op, effects, condition, fields
// - Flag written one exactly when condition holds
// - Result bit selects destination write
// - Immediate bit makes source field literal
// - Byte and half transfers, zero-extended
// - Long transfer, read sets zero flag
// - Local group takes four clocks
// - Sub-code zero loads clock configuration
// - Launch sets carry if none; halt core
// - Allocate lock number, carry when none
// - Release, acquire, drop lock; prior state
// - Codes four to seven are reserved
// - Rotate right or left by low five source bits
// - Shifts fill vacated bits with zero, or with carry for carry-fill codes
// - Arithmetic right shift keeps sign
// - Reverse low bits, clear the rest
// - Signed or unsigned limit, compare flags
// - Insert nine bits into chosen field
// - Jump, optionally storing return address
module cidp_core (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [9:0]                  addr,
  input  wire logic [31:0]                 wr_data,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [31:0]                 rd_data,
  input  wire logic [2:0]                  core_index,
  output logic                             hub_req,
  output cidp_pkg::cidp_hub_kind_type      hub_kind,
  output logic                             hub_write,
  output logic      [2:0]                  hub_sub,
  output logic      [15:0]                 hub_addr,
  output logic      [31:0]                 hub_wdata,
  input  wire logic                        hub_ack,
  input  wire logic [31:0]                 hub_rdata,
  input  wire logic                        hub_carry
);
  import cidp_pkg::*;

  cidp_core_type q;
  cidp_core_type d;
  logic [8:0]    mem_addr;
  logic          mem_we;
  logic [31:0]   mem_wd;
  logic [31:0]   mem_rdata;
  logic [31:0]   bitrev_d;
  logic [5:0]    op;
  logic [3:0]    cond;
  logic          cond_ok;
  logic [31:0]   res;
  logic [31:0]   hres;
  logic [63:0]   wide;
  logic [4:0]    n;
  logic          cr;
  logic          cvalid;
  logic          lim;
  logic          lt_s;
  logic          lt_u;
  logic          eq;

  cidp_ram cidp_ram_i (
    .clk   (clk),
    .addr  (mem_addr),
    .we    (mem_we),
    .wdata (mem_wd),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // field split
  assign op   = q.instr[`CIDP_OP_HI:`CIDP_OP_LO];
  assign cond = q.instr[`CIDP_COND_HI:`CIDP_COND_LO];
  assign cond_ok = cond[{q.c, q.z}];
  assign n    = q.sval[4:0];
  assign lt_s = $signed(mem_rdata) < $signed(q.sval);
  assign lt_u = mem_rdata < q.sval;
  assign eq   = mem_rdata == q.sval;

  for (genvar k = 0; k < 32; k++) begin : g_bitrev
    assign bitrev_d[k] = mem_rdata[31-k];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local execute datapath; destination value is the memory read data in ST_EXEC
  always_comb begin
    res    = mem_rdata;
    wide   = 64'h0;
    cr     = mem_rdata[0];
    cvalid = 1'b1;
    lim    = 1'b0;
    case (op)
      `CIDP_OPC_ROT_R: begin
        wide = {mem_rdata, mem_rdata} >> n;
        res  = wide[31:0];
      end
      `CIDP_OPC_ROT_L: begin
        wide = {mem_rdata, mem_rdata} << n;
        res  = wide[63:32];
        cr   = mem_rdata[31];
      end
      `CIDP_OPC_LSH_R: res = mem_rdata >> n;
      `CIDP_OPC_LSH_L: begin
        res = mem_rdata << n;
        cr  = mem_rdata[31];
      end
      // carry-fill shifts use the flag as it stood before
      `CIDP_OPC_CFILL_R: begin
        wide = {{32{q.c}}, mem_rdata} >> n;
        res  = wide[31:0];
      end
      `CIDP_OPC_CFILL_L: begin
        wide = {mem_rdata, {32{q.c}}} << n;
        res  = wide[63:32];
        cr   = mem_rdata[31];
      end
      `CIDP_OPC_ASH_R: res = $signed(mem_rdata) >>> n;
      `CIDP_OPC_BITREV: res = bitrev_d >> n;
      `CIDP_OPC_SMIN: begin
        res = lt_s ? q.sval : mem_rdata;
        cr  = lt_s;
        lim = 1'b1;
      end
      `CIDP_OPC_SMAX: begin
        res = lt_s ? mem_rdata : q.sval;
        cr  = lt_s;
        lim = 1'b1;
      end
      `CIDP_OPC_MIN: begin
        res = lt_u ? q.sval : mem_rdata;
        cr  = lt_u;
        lim = 1'b1;
      end
      `CIDP_OPC_MAX: begin
        res = lt_u ? mem_rdata : q.sval;
        cr  = lt_u;
        lim = 1'b1;
      end
      `CIDP_OPC_INS_SRC: begin
        res    = {mem_rdata[31:9], q.sval[8:0]};
        cvalid = 1'b0;
      end
      `CIDP_OPC_INS_DST: begin
        res    = {mem_rdata[31:18], q.sval[8:0], mem_rdata[8:0]};
        cvalid = 1'b0;
      end
      `CIDP_OPC_INS_TOP: begin
        res    = {q.sval[8:0], mem_rdata[22:0]};
        cvalid = 1'b0;
      end
      // return address is the word after the jump
      `CIDP_OPC_JUMP: begin
        res    = {mem_rdata[31:9], 9'(q.pc + 9'h1)};
        cvalid = 1'b0;
      end
      default: cvalid = 1'b0;
    endcase
  end

  // Shared-path answer; zero extension, own index
  always_comb begin
    case (q.hkind)
      HK_BYTE:  hres = {24'h0, hub_rdata[7:0]};
      HK_HALF:  hres = {16'h0, hub_rdata[15:0]};
      HK_LONG:  hres = hub_rdata;
      default:  hres = (q.hsub == `CIDP_SUB_INDEX) ? {29'h0, core_index} : hub_rdata;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d        = q;
    mem_addr = q.pc;
    mem_we   = 1'b0;
    mem_wd   = wr_data;
    d.rsel   = 1'b0;
    if (wr_stb && addr == `CIDP_ADDR_CTRL) begin
      d.run = wr_data[`CIDP_CTRL_RUN];
      if (q.st == ST_IDLE) begin
        d.pc = wr_data[`CIDP_CTRL_PC_HI:`CIDP_CTRL_PC_LO];
      end
    end
    // Bus reaches the register memory only while the core sits idle
    if (q.st == ST_IDLE && !q.run && !addr[9]) begin
      mem_addr = addr[8:0];
      mem_we   = wr_stb;
      d.rsel   = rd_stb;
    end
    if (rd_stb) begin
      case (addr)
        `CIDP_ADDR_CTRL: d.rreg = {22'h0, q.pc, q.run};
        `CIDP_ADDR_STAT: d.rreg = {16'h0, q.hreq, q.st == ST_IDLE, q.c, q.z, 3'h0, q.pc};
        default:         d.rreg = 32'h0;
      endcase
    end
    case (q.st)
      ST_IDLE: begin
        if (q.run) begin
          d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        d.st = q.run ? ST_SRC : ST_IDLE;
      end
      ST_SRC: begin
        d.instr  = mem_rdata;
        mem_addr = mem_rdata[`CIDP_SRC_HI:`CIDP_SRC_LO];
        d.st     = ST_DST;
      end
      ST_DST: begin
        d.sval   = q.instr[`CIDP_IFX] ? {23'h0, q.instr[`CIDP_SRC_HI:`CIDP_SRC_LO]} : mem_rdata;
        mem_addr = q.instr[`CIDP_DST_HI:`CIDP_DST_LO];
        d.st     = ST_EXEC;
      end
      ST_EXEC: begin
        d.st     = ST_FETCH;
        d.pc     = 9'(q.pc + 9'h1);
        mem_addr = q.instr[`CIDP_DST_HI:`CIDP_DST_LO];
        mem_wd   = res;
        if (cond_ok && op <= `CIDP_OPC_SHARED) begin
          d.st     = ST_HUB;
          d.hreq   = 1'b1;
          d.hkind  = cidp_hub_kind_type'(op[1:0]);
          d.hwr    = !q.instr[`CIDP_RFX] && op != `CIDP_OPC_SHARED;
          d.hsub   = q.sval[2:0];
          d.hwdata = mem_rdata;
          case (op)
            `CIDP_OPC_HALF: d.haddr = {q.sval[15:1], 1'b0};
            `CIDP_OPC_LONG: d.haddr = {q.sval[15:2], 2'h0};
            default:        d.haddr = q.sval[15:0];
          endcase
        end else if (cond_ok && op > `CIDP_OPC_RSV_HI) begin
          // reserved codes fall through as no-ops
          mem_we = q.instr[`CIDP_RFX];
          if (q.instr[`CIDP_ZFX]) begin
            d.z = lim ? eq : (res == 32'h0);
          end
          if (q.instr[`CIDP_CFX] && cvalid) begin
            d.c = cr;
          end
          if (op == `CIDP_OPC_JUMP) begin
            d.pc = q.sval[8:0];
          end
        end
      end
      ST_HUB: begin
        mem_addr = q.instr[`CIDP_DST_HI:`CIDP_DST_LO];
        mem_wd   = hres;
        if (hub_ack) begin
          d.hreq = 1'b0;
          d.st   = ST_FETCH;
          mem_we = q.instr[`CIDP_RFX];
          if (q.instr[`CIDP_ZFX] && q.instr[`CIDP_RFX] && (q.hkind != HK_SHARED ||
              q.hsub == `CIDP_SUB_INDEX || q.hsub == `CIDP_SUB_LAUNCH || q.hsub == `CIDP_SUB_ALLOC)) begin
            d.z = hres == 32'h0;
          end
          if (q.instr[`CIDP_CFX] && q.hkind == HK_SHARED && (q.hsub == `CIDP_SUB_LAUNCH ||
              q.hsub == `CIDP_SUB_ALLOC || q.hsub == `CIDP_SUB_ACQ || q.hsub == `CIDP_SUB_DROP)) begin
            d.c = hub_carry;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Memory read data is itself a register, so the bus answer stays registered
  assign rd_data   = q.rsel ? mem_rdata : q.rreg;
  assign hub_req   = q.hreq;
  assign hub_kind  = q.hkind;
  assign hub_write = q.hwr;
  assign hub_sub   = q.hsub;
  assign hub_addr  = q.haddr;
  assign hub_wdata = q.hwdata;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_four_clocks;
    q.st == ST_FETCH && q.run |=> q.st == ST_SRC ##1 q.st == ST_DST ##1 q.st == ST_EXEC;
  endproperty
  a_four_clocks: assert property (p_four_clocks) else $error("fetch to execute not 4 clocks");

  property p_hub_hold;
    hub_req && !hub_ack |=> hub_req && $stable(hub_addr) && $stable(hub_wdata);
  endproperty
  a_hub_hold: assert property (p_hub_hold) else $error("shared request dropped early");

  property p_zflag_keep;
    (q.st == ST_EXEC || q.st == ST_HUB) && !q.instr[`CIDP_ZFX] |=> $stable(q.z);
  endproperty
  a_zflag_keep: assert property (p_zflag_keep) else $error("zero flag changed without effect bit");

  property p_cond_skip;
    q.st == ST_EXEC && !cond_ok |-> !mem_we ##1 !hub_req;
  endproperty
  a_cond_skip: assert property (p_cond_skip) else $error("skipped instruction had an effect");

  property p_imm_src;
    q.st == ST_DST && q.instr[`CIDP_IFX] |=> q.sval == {23'h0, $past(q.instr[8:0])};
  endproperty
  a_imm_src: assert property (p_imm_src) else $error("literal source not taken");

  property p_jump;
    q.st == ST_EXEC && cond_ok && op == `CIDP_OPC_JUMP |=> q.pc == $past(q.sval[8:0]);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");

  property p_nores;
    q.st == ST_EXEC && !q.instr[`CIDP_RFX] |-> !mem_we;
  endproperty
  a_nores: assert property (p_nores) else $error("result written with write bit clear");

  property p_clk_cfg;
    q.st == ST_EXEC && cond_ok && op == `CIDP_OPC_SHARED && q.sval[2:0] == `CIDP_SUB_CLKCFG
      |=> hub_req && hub_sub == `CIDP_SUB_CLKCFG && hub_wdata[7:0] == $past(mem_rdata[7:0]);
  endproperty
  a_clk_cfg: assert property (p_clk_cfg) else $error("clock configuration request wrong");

  property p_reserved;
    q.st == ST_EXEC && op > `CIDP_OPC_SHARED && op <= `CIDP_OPC_RSV_HI |-> !mem_we ##1 q.st == ST_FETCH;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code had an effect");

  property p_lock_carry;
    q.st == ST_HUB && hub_ack && q.hkind == HK_SHARED && q.hsub == `CIDP_SUB_ACQ && q.instr[`CIDP_CFX]
      |=> q.c == $past(hub_carry);
  endproperty
  a_lock_carry: assert property (p_lock_carry) else $error("prior lock state not in carry");

  property p_rotr_carry;
    q.st == ST_EXEC && cond_ok && op == `CIDP_OPC_ROT_R && q.instr[`CIDP_CFX] |=> q.c == $past(mem_rdata[0]);
  endproperty
  a_rotr_carry: assert property (p_rotr_carry) else $error("rotate carry wrong");

  c_hub_done: cover property (q.st == ST_HUB && hub_ack);
  c_jump:     cover property (q.st == ST_EXEC && cond_ok && op == `CIDP_OPC_JUMP);
  c_skip:     cover property (q.st == ST_EXEC && !cond_ok);

endmodule // cidp_core

/* rtl/cidp_defs.svh */
// Field positions, opcodes, sub-codes and port addresses of the core decoder.
// Assumes: included by the package and by the core; definitions only.
`ifndef CIDP_DEFS_SVH
`define CIDP_DEFS_SVH

`define CIDP_OP_HI      31
`define CIDP_OP_LO      26
`define CIDP_ZFX        25
`define CIDP_CFX        24
`define CIDP_RFX        23
`define CIDP_IFX        22
`define CIDP_COND_HI    21
`define CIDP_COND_LO    18
`define CIDP_DST_HI     17
`define CIDP_DST_LO     9
`define CIDP_SRC_HI     8
`define CIDP_SRC_LO     0

`define CIDP_OPC_BYTE   6'h00
`define CIDP_OPC_HALF   6'h01
`define CIDP_OPC_LONG   6'h02
`define CIDP_OPC_SHARED 6'h03
`define CIDP_OPC_RSV_HI 6'h07
`define CIDP_OPC_ROT_R   6'h08
`define CIDP_OPC_ROT_L   6'h09
`define CIDP_OPC_LSH_R   6'h0a
`define CIDP_OPC_LSH_L   6'h0b
`define CIDP_OPC_CFILL_R 6'h0c
`define CIDP_OPC_CFILL_L 6'h0d
`define CIDP_OPC_ASH_R   6'h0e
`define CIDP_OPC_BITREV  6'h0f
`define CIDP_OPC_SMIN    6'h10
`define CIDP_OPC_SMAX    6'h11
`define CIDP_OPC_MIN     6'h12
`define CIDP_OPC_MAX     6'h13
`define CIDP_OPC_INS_SRC 6'h14
`define CIDP_OPC_INS_DST 6'h15
`define CIDP_OPC_INS_TOP 6'h16
`define CIDP_OPC_JUMP    6'h17

`define CIDP_SUB_CLKCFG 3'h0
`define CIDP_SUB_INDEX  3'h1
`define CIDP_SUB_LAUNCH 3'h2
`define CIDP_SUB_HALT   3'h3
`define CIDP_SUB_ALLOC  3'h4
`define CIDP_SUB_ACQ    3'h6
`define CIDP_SUB_DROP   3'h7

`define CIDP_ADDR_CTRL  10'h200
`define CIDP_ADDR_STAT  10'h201
`define CIDP_CTRL_RUN   0
`define CIDP_CTRL_PC_HI 9
`define CIDP_CTRL_PC_LO 1
`define CIDP_RAM_WORDS  512

`endif

/* rtl/cidp_pkg.sv */
// Types shared by the core decoder and its shared-side model.
// Assumes: cidp_defs.svh on the include path.
`include "cidp_defs.svh"

package cidp_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_SRC, ST_DST, ST_EXEC, ST_HUB} cidp_state_type;

  typedef enum logic [1:0] {HK_BYTE, HK_HALF, HK_LONG, HK_SHARED} cidp_hub_kind_type;

  typedef struct packed {
    cidp_state_type    st;
    logic [8:0]        pc;
    logic [31:0]       instr;
    logic [31:0]       sval;
    logic              z;
    logic              c;
    logic              run;
    logic              hreq;
    cidp_hub_kind_type hkind;
    logic              hwr;
    logic [2:0]        hsub;
    logic [15:0]       haddr;
    logic [31:0]       hwdata;
    logic              rsel;
    logic [31:0]       rreg;
  } cidp_core_type;

endpackage

/* rtl/cidp_ram.sv */
// Core register memory: 512 words of 32 bits, one port, registered read data.
// Assumes: a single clock; write and read of the same word return the old data.
`timescale 1ns/100ps
`include "cidp_defs.svh"

module cidp_ram (
  input  wire logic        clk,
  input  wire logic [8:0]  addr,
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata
);

  logic [31:0] mem [0:`CIDP_RAM_WORDS-1];

  // No reset: contents are loaded by software before the core runs
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // cidp_ram
